// >>> verilog/ppsg_top.sv
// Purpose: second pulse output generator with loopbacks
// Assumes: local time counter supplied on clk_i domain
// Notes: strobe pin is a two-way pin split in three signals
//
// Decided for this implementation: the plain strobed port and the address map.
module ppsg_top
  import ppsg_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  // local time counter
  input wire logic [ppsg_pkg::NS_W-1:0] ltc_ns_i,
  input wire logic [ppsg_pkg::SEC_W-1:0] ltc_sec_i,
  // pulse pin and return
  output logic second_pulse_out_o,
  input wire logic pulse_return_input_i,
  output logic pulse_return_sync_o,
  // strobe pin
  input wire logic strobe_pin_i,
  output logic strobe_pin_o,
  output logic strobe_pin_oe_o,
  output logic strobe_sync_o,
  // edge block enables
  output logic [ppsg_pkg::HIRES_W-1:0] hires_block_enables_o
);
  import ppsg_pkg::*;

  function automatic logic [4:0] clamp_bit(input logic [4:0] b);
    if (b < ALT_BIT_MIN) begin
      return ALT_BIT_MIN;
    end else if (b > ALT_BIT_MAX) begin
      return ALT_BIT_MAX;
    end
    return b;
  endfunction

  function automatic logic [31:0] pad_ns(input logic [NS_W-1:0] v);
    return {{(32-NS_W){1'b0}}, v};
  endfunction

  // configuration
  logic alt_en_ff;
  logic [4:0] alt_bit_select_ff;
  logic strobe_to_pulse_loop_en_ff;
  logic strobe_pin_drive_loop_en_ff;
  logic pulse_to_strobe_loop_en_ff;
  logic serial_timeofday_out_enable_ff;
  logic [NS_W-1:0] pulse_assert_threshold_ff;
  logic [NS_W-1:0] pulse_width_setting_ff;
  logic synthesizer_enable_ff;
  logic [NS_W-1:0] synth_high_time_ns_ff;
  logic [NS_W-1:0] synth_low_time_ns_ff;
  logic [HIRES_W-1:0] hires_block_enables_ff;
  // pulse state
  logic [NS_W-1:0] prev_ns_ff;
  logic normal_pulse_ff;
  logic [NS_W-1:0] width_cnt_ff;
  logic alt_ff;
  logic [1:0] oe_cnt_ff;
  logic pin_drive_ff;
  logic out_ff;
  ppsg_src_t src;
  logic [31:0] rdata_ff;
  // serial time of day
  logic [SEC_W-1:0] tod_shift_ff;
  logic [5:0] tod_bits_ff;
  logic [3:0] tod_pos_ff;
  logic [7:0] tod_tick_ff;
  logic tod_line_ff;
  logic tod_busy;
  // synchronisers
  logic [1:0] strobe_sync_ff;
  logic [1:0] ret_sync_ff;
  logic trigger;
  logic wrap;
  logic crossed;
  ppsg_synth_if sy ();

  // threshold crossing; zero threshold means second wrap
  assign wrap = ltc_ns_i < prev_ns_ff;
  assign crossed = (prev_ns_ff <= pulse_assert_threshold_ff) &&
                   (ltc_ns_i > pulse_assert_threshold_ff);
  assign trigger = (pulse_assert_threshold_ff == '0) ? wrap : crossed;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_ns_ff <= '0;
    end else begin
      prev_ns_ff <= ltc_ns_i;
    end
  end

  // register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alt_en_ff <= 1'b0;
      alt_bit_select_ff <= ALT_BIT_MIN;
      strobe_to_pulse_loop_en_ff <= 1'b0;
      strobe_pin_drive_loop_en_ff <= 1'b0;
      pulse_to_strobe_loop_en_ff <= 1'b0;
      serial_timeofday_out_enable_ff <= 1'b0;
      pulse_assert_threshold_ff <= '0;
      pulse_width_setting_ff <= RST_WIDTH;
      synthesizer_enable_ff <= 1'b0;
      synth_high_time_ns_ff <= RST_SYNTH_T;
      synth_low_time_ns_ff <= RST_SYNTH_T;
      hires_block_enables_ff <= '0;
    end else if (reg_we_i) begin
      case (reg_addr_i)
        REG_CTRL: begin
          alt_en_ff <= reg_wdata_i[CTRL_ALT_EN];
          alt_bit_select_ff <= clamp_bit(reg_wdata_i[CTRL_SEL_HI:CTRL_SEL_LO]);
          strobe_to_pulse_loop_en_ff <= reg_wdata_i[CTRL_S2P];
          strobe_pin_drive_loop_en_ff <= reg_wdata_i[CTRL_PINDRV];
          pulse_to_strobe_loop_en_ff <= reg_wdata_i[CTRL_P2S];
          serial_timeofday_out_enable_ff <= reg_wdata_i[CTRL_TOD];
        end
        REG_THRESH: pulse_assert_threshold_ff <= reg_wdata_i[NS_W-1:0];
        REG_WIDTH: pulse_width_setting_ff <= reg_wdata_i[NS_W-1:0];
        REG_SYNTH: synthesizer_enable_ff <= reg_wdata_i[0];
        REG_SYNTH_HI: synth_high_time_ns_ff <= reg_wdata_i[NS_W-1:0];
        REG_SYNTH_LO: synth_low_time_ns_ff <= reg_wdata_i[NS_W-1:0];
        REG_HIRES: hires_block_enables_ff <= reg_wdata_i[HIRES_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // register reads, data one cycle later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= '0;
    end else if (reg_re_i) begin
      case (reg_addr_i)
        REG_CTRL: rdata_ff <= {16'h0000, serial_timeofday_out_enable_ff,
                               pulse_to_strobe_loop_en_ff, strobe_pin_drive_loop_en_ff,
                               strobe_to_pulse_loop_en_ff, 3'h0, alt_bit_select_ff,
                               3'h0, alt_en_ff};
        REG_THRESH: rdata_ff <= pad_ns(pulse_assert_threshold_ff);
        REG_WIDTH: rdata_ff <= pad_ns(pulse_width_setting_ff);
        REG_SYNTH: rdata_ff <= {31'h00000000, synthesizer_enable_ff};
        REG_SYNTH_HI: rdata_ff <= pad_ns(synth_high_time_ns_ff);
        REG_SYNTH_LO: rdata_ff <= pad_ns(synth_low_time_ns_ff);
        REG_HIRES: rdata_ff <= {27'h0000000, hires_block_enables_ff};
        REG_STATUS: rdata_ff <= {16'h0000, 3'h0, src, 4'h0, tod_busy,
                                 strobe_pin_oe_o, normal_pulse_ff, out_ff};
        default: rdata_ff <= '0;
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end
  assign reg_rdata_o = rdata_ff;

  // normal pulse with width timer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      normal_pulse_ff <= 1'b0;
      width_cnt_ff <= '0;
    end else if (trigger) begin
      normal_pulse_ff <= 1'b1;
      width_cnt_ff <= CLK_NS;
    end else if (normal_pulse_ff) begin
      if (width_cnt_ff >= pulse_width_setting_ff) begin
        normal_pulse_ff <= 1'b0;
      end else begin
        width_cnt_ff <= width_cnt_ff + CLK_NS;
      end
    end
  end

  // alternate bit, no width control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alt_ff <= 1'b0;
    end else begin
      alt_ff <= ltc_ns_i[alt_bit_select_ff];
    end
  end

  // synthesizer
  assign sy.enable = synthesizer_enable_ff;
  assign sy.high_ns = synth_high_time_ns_ff;
  assign sy.low_ns = synth_low_time_ns_ff;
  ppsg_synth u_synth (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sy(sy.gen)
  );

  // serial time of day: start high, 8 bits lsb first, stop low
  assign tod_busy = tod_bits_ff != '0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tod_shift_ff <= '0;
      tod_bits_ff <= '0;
      tod_pos_ff <= '0;
      tod_tick_ff <= '0;
      tod_line_ff <= 1'b1;
    end else if (!tod_busy) begin
      tod_line_ff <= 1'b1;
      if (serial_timeofday_out_enable_ff && wrap) begin
        tod_shift_ff <= ltc_sec_i;
        tod_bits_ff <= TOD_NBITS;
        tod_pos_ff <= '0;
        tod_tick_ff <= '0;
        tod_line_ff <= 1'b1;
      end
    end else if (tod_tick_ff == TOD_BIT_LAST) begin
      tod_tick_ff <= '0;
      tod_bits_ff <= tod_bits_ff - 6'h01;
      tod_pos_ff <= (tod_pos_ff == 4'h9) ? 4'h0 : tod_pos_ff + 4'h1;
      if (tod_pos_ff == 4'h8) begin
        tod_line_ff <= 1'b0;
      end else if (tod_pos_ff == 4'h9) begin
        tod_line_ff <= 1'b1;
      end else begin
        tod_line_ff <= tod_shift_ff[0];
        tod_shift_ff <= tod_shift_ff >> 1;
      end
    end else begin
      tod_tick_ff <= tod_tick_ff + 8'h01;
    end
  end

  // fixed source priority
  always_comb begin
    if (strobe_to_pulse_loop_en_ff) begin
      src = SRC_STROBE;
    end else if (serial_timeofday_out_enable_ff) begin
      src = SRC_TOD;
    end else if (synthesizer_enable_ff) begin
      src = SRC_SYNTH;
    end else if (alt_en_ff) begin
      src = SRC_ALT;
    end else begin
      src = SRC_NORMAL;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_ff <= 1'b0;
    end else begin
      case (src)
        SRC_TOD: out_ff <= tod_line_ff;
        SRC_SYNTH: out_ff <= sy.wave;
        SRC_ALT: out_ff <= alt_ff;
        SRC_NORMAL: out_ff <= normal_pulse_ff;
        default: out_ff <= 1'b0;
      endcase
    end
  end

  // raw strobe pin straight out, no synchroniser
  assign second_pulse_out_o = strobe_to_pulse_loop_en_ff ? strobe_pin_i : out_ff;

  // strobe pin drive: enable the two cycles after trigger
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oe_cnt_ff <= '0;
      pin_drive_ff <= 1'b0;
    end else if (strobe_pin_drive_loop_en_ff && trigger && (src == SRC_NORMAL)) begin
      oe_cnt_ff <= 2'h1;
      pin_drive_ff <= 1'b1;
    end else if (oe_cnt_ff != '0) begin
      oe_cnt_ff <= oe_cnt_ff - 2'h1;
      pin_drive_ff <= 1'b1;
    end else begin
      pin_drive_ff <= 1'b0;
    end
  end
  assign strobe_pin_oe_o = strobe_pin_drive_loop_en_ff && (src == SRC_NORMAL) &&
                           pin_drive_ff;
  assign strobe_pin_o = out_ff;

  // strobe input path with pulse tap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strobe_sync_ff <= '0;
      ret_sync_ff <= '0;
    end else begin
      strobe_sync_ff <= {strobe_sync_ff[0], strobe_pin_i};
      ret_sync_ff <= {ret_sync_ff[0], pulse_return_input_i};
    end
  end
  assign strobe_sync_o = pulse_to_strobe_loop_en_ff ? out_ff : strobe_sync_ff[1];
  assign pulse_return_sync_o = ret_sync_ff[1];
  assign hires_block_enables_o = hires_block_enables_ff;
endmodule

// >>> verilog/ppsg_pkg.sv
// Purpose: constants for the second pulse output generator
// Assumes: one 50 MHz clock, the local time counter arrives on that clock
// Notes: register offsets are byte addresses of 32-bit words
// Overview of operation
// - pulse asserts when nanoseconds pass threshold
// - zero threshold pulses at each second wrap
// - normal pulse held for programmed width
// - alternate mode drives one counter bit
// - alternate mode has no width control
// - selectable bits four to seventeen only
// - alternate output follows counter jumps and jitter
// - synthesizer enable replaces pulse with toggle
// - synthesizer alternates programmed high and low
// - events resolved against nanosecond counter value
// - time counter clock fixed at 50 MHz, 20 ns a clock
// - five edge blocks, each enabled separately
// - strobe pin unsynchronised straight to pulse
// - strobe pin enable one clock early, two
// - pulse output tapped into strobe path
// - serial time of day drives pulse pin
package ppsg_pkg;
  localparam int unsigned NS_W = 30;
  localparam int unsigned SEC_W = 48;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned CLK_PERIOD_NS = 1000 / CLK_MHZ;
  localparam logic [NS_W-1:0] CLK_NS = NS_W'(CLK_PERIOD_NS);
  localparam int unsigned TOD_BIT_US = 1;
  localparam int unsigned TOD_BIT_CYC = TOD_BIT_US * CLK_MHZ;
  localparam logic [7:0] TOD_BIT_LAST = 8'(TOD_BIT_CYC - 1);
  localparam logic [5:0] TOD_NBITS = 6'h3c;
  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_THRESH = 8'h04;
  localparam logic [7:0] REG_WIDTH = 8'h08;
  localparam logic [7:0] REG_SYNTH = 8'h0c;
  localparam logic [7:0] REG_SYNTH_HI = 8'h10;
  localparam logic [7:0] REG_SYNTH_LO = 8'h14;
  localparam logic [7:0] REG_HIRES = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;
  // control fields
  localparam int unsigned CTRL_ALT_EN = 0;
  localparam int unsigned CTRL_SEL_LO = 4;
  localparam int unsigned CTRL_SEL_HI = 8;
  localparam int unsigned CTRL_S2P = 12;
  localparam int unsigned CTRL_PINDRV = 13;
  localparam int unsigned CTRL_P2S = 14;
  localparam int unsigned CTRL_TOD = 15;
  localparam int unsigned HIRES_W = 5;
  localparam logic [4:0] ALT_BIT_MIN = 5'h04;
  localparam logic [4:0] ALT_BIT_MAX = 5'h11;
  // reset values
  localparam logic [NS_W-1:0] RST_WIDTH = 30'h05f5e100;
  localparam logic [NS_W-1:0] RST_SYNTH_T = 30'h00000032;
  typedef enum logic [4:0] {
    SRC_NORMAL = 5'h01,
    SRC_ALT = 5'h02,
    SRC_SYNTH = 5'h04,
    SRC_TOD = 5'h08,
    SRC_STROBE = 5'h10
  } ppsg_src_t;
endpackage

// >>> verilog/ppsg_synth_if.sv
// Purpose: carrier between top and synthesizer
// Assumes: same clock on both sides
// Notes: none
interface ppsg_synth_if;
  import ppsg_pkg::*;
  logic enable;
  logic [NS_W-1:0] high_ns;
  logic [NS_W-1:0] low_ns;
  logic wave;
  modport ctl (output enable, output high_ns, output low_ns, input wave);
  modport gen (input enable, input high_ns, input low_ns, output wave);
endinterface

// >>> verilog/ppsg_synth.sv
// Purpose: programmable high and low time toggle generator
// Assumes: each clock advances time by one clock period
// Notes: remainder carried so times alternate around target
module ppsg_synth
  import ppsg_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control and wave
  ppsg_synth_if.gen sy
);
  logic [NS_W-1:0] acc_ff;
  logic wave_ff;
  logic [NS_W-1:0] target;
  logic [NS_W-1:0] nxt_acc;

  assign target = wave_ff ? sy.high_ns : sy.low_ns;
  assign nxt_acc = acc_ff + CLK_NS;
  assign sy.wave = wave_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i || !sy.enable) begin
      acc_ff <= '0;
      wave_ff <= 1'b0;
    end else if (nxt_acc >= target) begin
      acc_ff <= nxt_acc - target;
      wave_ff <= !wave_ff;
    end else begin
      acc_ff <= nxt_acc;
    end
  end
endmodule

// >>> sim/ppsg_props.sv
// Purpose: port checker for the pulse generator
// Assumes: bound to ppsg_top, one clock
// Notes: settings mirrored from register writes
module ppsg_props
  import ppsg_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [31:0] reg_rdata_o,
  // time and pins
  input wire logic [ppsg_pkg::NS_W-1:0] ltc_ns_i,
  input wire logic [ppsg_pkg::SEC_W-1:0] ltc_sec_i,
  input wire logic second_pulse_out_o,
  input wire logic pulse_return_input_i,
  input wire logic pulse_return_sync_o,
  input wire logic strobe_pin_i,
  input wire logic strobe_pin_o,
  input wire logic strobe_pin_oe_o,
  input wire logic strobe_sync_o,
  input wire logic [ppsg_pkg::HIRES_W-1:0] hires_block_enables_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] ctrl_ff;
  logic syn_ff;
  logic [NS_W-1:0] th_ff;
  logic [NS_W-1:0] w_ff;
  logic [NS_W-1:0] hi_ff;
  logic [NS_W-1:0] lo_ff;
  logic [NS_W-1:0] ns1_ff;
  logic [NS_W-1:0] ns2_ff;
  logic [1:0] quiet_ff;
  logic [31:0] hcnt_ff;
  logic base;
  logic run_norm;
  logic run_alt;
  logic run_syn;
  logic trig;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // shadow of written settings
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= 16'h0040;
      syn_ff <= 1'b0;
      th_ff <= '0;
      w_ff <= RST_WIDTH;
      hi_ff <= RST_SYNTH_T;
      lo_ff <= RST_SYNTH_T;
    end else if (reg_we_i) begin
      case (reg_addr_i)
        REG_CTRL: ctrl_ff <= reg_wdata_i[15:0];
        REG_THRESH: th_ff <= reg_wdata_i[NS_W-1:0];
        REG_WIDTH: w_ff <= reg_wdata_i[NS_W-1:0];
        REG_SYNTH: syn_ff <= reg_wdata_i[0];
        REG_SYNTH_HI: hi_ff <= reg_wdata_i[NS_W-1:0];
        REG_SYNTH_LO: lo_ff <= reg_wdata_i[NS_W-1:0];
        default: ;
      endcase
    end
  end
  // settle count after any write
  always_ff @(posedge clk_i) begin
    if (rst_i || reg_we_i) quiet_ff <= 2'h0;
    else if (quiet_ff != 2'h3) quiet_ff <= quiet_ff + 2'h1;
  end
  // time history and high run length
  always_ff @(posedge clk_i) begin
    ns1_ff <= ltc_ns_i;
    ns2_ff <= ns1_ff;
    if (rst_i || !second_pulse_out_o) hcnt_ff <= 32'h0;
    else hcnt_ff <= hcnt_ff + 32'h1;
  end
  assign base = quiet_ff == 2'h3 && !ctrl_ff[CTRL_S2P] && !ctrl_ff[CTRL_TOD];
  assign run_syn = base && syn_ff;
  assign run_alt = base && !syn_ff && ctrl_ff[CTRL_ALT_EN] && ctrl_ff[8:4] >= ALT_BIT_MIN
    && ctrl_ff[8:4] <= ALT_BIT_MAX;
  assign run_norm = base && !syn_ff && !ctrl_ff[CTRL_ALT_EN];
  assign trig = th_ff == '0 ? ltc_ns_i < ns1_ff : ns1_ff <= th_ff && ltc_ns_i > th_ff;
  sequence oe_burst_s;
    strobe_pin_oe_o ##1 !strobe_pin_oe_o;
  endsequence
  sequence synth_high_s;
    second_pulse_out_o ##[1:2] !second_pulse_out_o;
  endsequence
  a_oe_two_cycles: assert property ($rose(strobe_pin_oe_o) |=> oe_burst_s)
    else $error("pin enable not two cycles");
  a_oe_leads_pulse: assert property ($rose(strobe_pin_oe_o) && !second_pulse_out_o |->
    ##1 second_pulse_out_o) else $error("pulse not one cycle after pin enable");
  a_pin_carries_pulse: assert property ($rose(strobe_pin_oe_o) |=> strobe_pin_oe_o && strobe_pin_o)
    else $error("pulse not driven on strobe pin");
  a_trig_gives_pulse: assert property (run_norm && trig && !second_pulse_out_o |->
    ##2 second_pulse_out_o) else $error("no pulse after trigger");
  a_norm_width: assert property (run_norm && $fell(second_pulse_out_o) |->
    hcnt_ff >= w_ff / CLK_NS && hcnt_ff <= w_ff / CLK_NS + 2) else $error("pulse width wrong");
  a_alt_follows: assert property (run_alt |-> second_pulse_out_o == ns2_ff[ctrl_ff[8:4]])
    else $error("alternate output not counter bit");
  a_synth_high: assert property (run_syn && hi_ff == 30'h32 && lo_ff == 30'h32
    && $rose(second_pulse_out_o) |=> synth_high_s) else $error("synth high time wrong");
  a_synth_toggles: assert property (run_syn && $fell(second_pulse_out_o) |->
    ##[1:8] second_pulse_out_o) else $error("synth output stuck low");
  a_strobe_raw: assert property (quiet_ff == 2'h3 && ctrl_ff[CTRL_S2P] |->
    second_pulse_out_o == strobe_pin_i) else $error("strobe not on pulse pin");
  a_tap_strobe: assert property (quiet_ff == 2'h3 && ctrl_ff[CTRL_P2S] && !ctrl_ff[CTRL_S2P]
    && $rose(second_pulse_out_o) |-> ##[0:2] strobe_sync_o) else $error("pulse not in strobe path");
  a_hires_write: assert property (reg_we_i && reg_addr_i == REG_HIRES |=>
    hires_block_enables_o == $past(reg_wdata_i[HIRES_W-1:0])) else $error("edge enables wrong");
endmodule
bind ppsg_top ppsg_props ppsg_props_i (
  .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .ltc_ns_i(ltc_ns_i),
  .ltc_sec_i(ltc_sec_i), .second_pulse_out_o(second_pulse_out_o),
  .pulse_return_input_i(pulse_return_input_i), .pulse_return_sync_o(pulse_return_sync_o),
  .strobe_pin_i(strobe_pin_i), .strobe_pin_o(strobe_pin_o), .strobe_pin_oe_o(strobe_pin_oe_o),
  .strobe_sync_o(strobe_sync_o), .hires_block_enables_o(hires_block_enables_o)
);

// >>> sim/ppsg_far.sv
// Purpose: far timing device on the pulse pins
// Assumes: drives strobe unless the design drives it
// Notes: echo delay set by dly
module ppsg_far #(
  parameter int DLY = 3
) (
  // clock
  input wire logic clk_i,
  // from design
  input wire logic pulse_i,
  input wire logic oe_i,
  input wire logic pin_i,
  // from bench
  input wire logic strobe_cmd_i,
  // to design
  output logic return_o,
  output logic strobe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DLY-1:0] dly_ff;
  // far end echoes the pulse back
  always_ff @(posedge clk_i) dly_ff <= {dly_ff[DLY-2:0], pulse_i};
  assign return_o = dly_ff[DLY-1];
  // pin level from whichever side drives
  assign strobe_o = oe_i ? pin_i : strobe_cmd_i;
endmodule

// >>> sim/tb.sv
// Purpose: self-checking bench for the pulse generator
// Assumes: time counter modelled here, 20 ns a clock
// Notes: strobe pin level resolved in the far model
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ppsg_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic ld = 1'b0;
  logic s_cmd = 1'b0;
  logic [NS_W-1:0] ld_v = '0;
  logic [NS_W-1:0] ns = '0;
  logic [SEC_W-1:0] sec = '0;
  logic [NS_W-1:0] hist[40];
  logic [31:0] rdata;
  logic [HIRES_W-1:0] hires;
  logic out, ret, ret_sync, pin, pin_o, oe, s_sync;
  int bits[3] = '{4, 9, 17};
  logic lvl[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  int miscompares = 0;
  int checks = 0;
  int h, l, h2, l2, n;
  always #10 clk_i = ~clk_i;
  // local time counter with load
  always @(posedge clk_i) begin
    if (ld) ns <= ld_v;
    else if (ns >= 30'h3b9ac9ec) begin
      ns <= '0;
      sec <= sec + 48'h1;
    end else ns <= ns + CLK_NS;
  end
  ppsg_top ppsg_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .ltc_ns_i(ns), .ltc_sec_i(sec),
    .second_pulse_out_o(out), .pulse_return_input_i(ret), .pulse_return_sync_o(ret_sync),
    .strobe_pin_i(pin), .strobe_pin_o(pin_o), .strobe_pin_oe_o(oe), .strobe_sync_o(s_sync),
    .hires_block_enables_o(hires)
  );
  ppsg_far #(.DLY(3)) ppsg_far_i (
    .clk_i(clk_i), .pulse_i(out), .oe_i(oe), .pin_i(pin_o), .strobe_cmd_i(s_cmd),
    .return_o(ret), .strobe_o(pin)
  );
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk_i);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge clk_i);
    addr <= a;
    re <= 1'b1;
    @(posedge clk_i);
    re <= 1'b0;
    #1;
    chk(nm, exp, rdata);
  endtask
  task automatic ldns(input logic [NS_W-1:0] v);
    @(posedge clk_i);
    ld_v <= v;
    ld <= 1'b1;
    @(posedge clk_i);
    ld <= 1'b0;
  endtask
  task automatic wait_lvl(input logic v, output int w);
    w = 0;
    tick();
    while (out !== v && w < 60) begin
      tick();
      w++;
    end
  endtask
  task automatic seg(output int hc, output int lc);
    wait_lvl(1'b0, hc);
    wait_lvl(1'b1, hc);
    wait_lvl(1'b0, hc);
    wait_lvl(1'b1, lc);
    hc++;
    lc++;
  endtask
  task automatic pulse_run(input logic [NS_W-1:0] s, input int rlo, rhi, wlo, whi);
    int w;
    ldns(s);
    wait_lvl(1'b1, w);
    chk("rise_time", 1, 32'(w >= rlo && w <= rhi));
    wait_lvl(1'b0, w);
    w++;
    chk("pulse_width", 1, 32'(w >= wlo && w <= whi));
    chk("return_sync", 1, 32'(ret_sync));
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(REG_THRESH, 32'h0, "thresh");
    rd(REG_WIDTH, 32'h05f5e100, "width");
    rd(REG_SYNTH_HI, 32'h32, "synth_hi");
    rd(REG_SYNTH_LO, 32'h32, "synth_lo");
    rd(REG_CTRL, 32'h40, "ctrl");
    wr(8'h20, 32'hffff);
    rd(8'h20, 32'h0, "unmapped");
    // edge block enables
    wr(REG_HIRES, 32'h15);
    tick();
    chk("hires_o", 32'h15, 32'(hires));
    wr(REG_HIRES, 32'h0a);
    rd(REG_HIRES, 32'h0a, "hires");
    // second wrap with pin drive, then threshold
    wr(REG_WIDTH, 32'h64);
    wr(REG_CTRL, 32'h2040);
    pulse_run(30'h3b9ac98c, 4, 12, 5, 7);
    wr(REG_WIDTH, 32'h190);
    wr(REG_THRESH, 32'h3e8);
    pulse_run(30'h1f4, 24, 32, 20, 22);
    // alternate bit mode
    foreach (bits[i]) begin
      wr(REG_CTRL, 32'h1 | (32'(bits[i]) << 4));
      ldns(30'h1ff00);
      for (int k = 0; k < 40; k++) begin
        tick();
        hist[k] = ns;
        if (k > 1) chk("alt_bit", 32'(hist[k-2][bits[i]]), 32'(out));
      end
    end
    wr(REG_CTRL, 32'h31);
    rd(REG_CTRL, 32'h41, "sel_low");
    wr(REG_CTRL, 32'h1f1);
    rd(REG_CTRL, 32'h111, "sel_high");
    // synthesizer, pulse tapped into strobe path
    wr(REG_CTRL, 32'h4040);
    wr(REG_SYNTH, 32'h1);
    seg(h, l);
    seg(h2, l2);
    chk("synth_two_periods", 10, 32'(h + l + h2 + l2));
    wr(REG_SYNTH_HI, 32'h64);
    wr(REG_SYNTH_LO, 32'h3c);
    seg(h, l);
    chk("synth_high", 5, 32'(h));
    chk("synth_low", 3, 32'(l));
    wr(REG_CTRL, 32'h4041);
    seg(h, l);
    chk("synth_over_alt", 8, 32'(h + l));
    // strobe straight to pulse pin
    wr(REG_CTRL, 32'h1040);
    tick();
    foreach (lvl[i]) begin
      @(posedge clk_i);
      s_cmd <= lvl[i];
      #1;
      chk("strobe_loop", 32'(lvl[i]), 32'(out));
    end
    // serial time of day idles high
    wr(REG_CTRL, 32'h8040);
    repeat (3) tick();
    n = 0;
    repeat (20) begin
      tick();
      if (out === 1'b1) n++;
    end
    chk("tod_idle", 20, 32'(n));
    rd(REG_STATUS, 32'h801, "status");
    tick();
    chk("rdata_clear", 32'h0, rdata);
    // serial time of day stream after a second wrap, sampled mid bit
    ldns(30'h3b9ac98c);
    repeat (83) tick();
    for (int k = 0; k < 9; k++) begin
      chk("tod_bit", (k < 8) ? 32'(sec[k]) : 32'h0, 32'(out));
      repeat (50) tick();
    end
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    test_done();
  end
endmodule
